/* rtl/dac_display_cfg.svh */
// Offsets, field positions, reset values and timing counts of the display controller.
// Assumes a 100 MHz core clock; included by every design file of the block except the package.
`ifndef DAC_DISPLAY_CFG_SVH
`define DAC_DISPLAY_CFG_SVH
`define CLK_PERIOD_NS    10
`define OFS_CHAN_BASE    8'h00
`define OFS_DSR          8'h10
`define OFS_EVT          8'h14
`define OFS_MASK         8'h18
`define ADR_PAGE_MASK    8'hF0
`define DSR_STORE        0
`define DSR_ERASE        1
`define DSR_SUPER        2
`define DSR_FAST         3
`define DSR_IE           4
`define DSR_PEN          5
`define DSR_TWOS         6
`define DSR_READY        7
`define DSR_DLY_LONG     8
`define DSR_DLY_EXT      9
`define DSR_WMASK        10'h37F
`define DSR_RESET        10'h080
`define EVT_DOT          0
`define EVT_ERASE        1
`define CODE_MSB         12'h800
`define STROBE_SHORT_NS  2000
`define STROBE_LONG_NS   6000
`define DLY_FAST_NS      3000
`define DLY_SHORT_NS     20000
`define DLY_LONG_NS      80000
`define NS_TO_CYC(ns)    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_SHORT_CYC `NS_TO_CYC(`STROBE_SHORT_NS)
`define STROBE_LONG_CYC  `NS_TO_CYC(`STROBE_LONG_NS)
`define DLY_FAST_CYC     `NS_TO_CYC(`DLY_FAST_NS)
`define DLY_SHORT_CYC    `NS_TO_CYC(`DLY_SHORT_NS)
`define DLY_LONG_CYC     `NS_TO_CYC(`DLY_LONG_NS)
`define IRQ_LEVEL_DEF    3'h4
`define IRQ_VECTOR_DEF   9'h0F0
`endif

/* rtl/dac_display_pkg.sv */
// Types shared by the display controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dac_display_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b00,
		SEQ_SETTLE = 2'b01,
		SEQ_STROBE = 2'b10
	} seq_state_t;

	typedef struct packed {
		seq_state_t  state;
		logic [13:0] cnt;
		logic        wide;
		logic        strobe;
		logic        done;
	} seq_regs_t;

	typedef struct packed {
		logic       req;
		logic       served;
		logic       vec_valid;
		logic [8:0] vector;
		logic [2:0] level;
	} irq_regs_t;

	typedef struct packed {
		logic             ack;
		logic [31:0]      rdata;
		logic [3:0][11:0] chan;
		logic [3:0][11:0] dac;
		logic [9:0]       dsr;
		logic [1:0]       evt;
		logic [1:0]       mask;
		logic             irq;
		logic             start;
	} top_regs_t;
endpackage

/* rtl/dot_sequencer.sv */
// Settling delay followed by the dot strobe pulse.
// Assumes start_i is a one-cycle pulse and all inputs are synchronous to core_clk_i.
`include "dac_display_cfg.svh"
module dot_sequencer #(
	parameter int LONG_DELAY_CYCLES = `DLY_LONG_CYC
)(
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	input  wire logic fast_i,
	input  wire logic long_i,
	input  wire logic ext_i,
	input  wire logic store_i,
	input  wire logic delay_return_i,
	output logic      strobe_o,
	output logic      done_o
);
	dac_display_pkg::seq_regs_t q;
	dac_display_pkg::seq_regs_t d;
	logic [13:0] dly_lim;
	logic [13:0] wid_lim;
	logic        dly_end;

	always_comb
	begin
		d = q;
		d.done = 1'b0;
		dly_lim = fast_i ? 14'(`DLY_FAST_CYC) :
			long_i ? 14'(LONG_DELAY_CYCLES) : 14'(`DLY_SHORT_CYC);
		wid_lim = q.wide ? 14'(`STROBE_LONG_CYC) : 14'(`STROBE_SHORT_CYC);
		// Fast mode ignores the external return; it is a fixed short settle
		dly_end = (ext_i && !fast_i) ? delay_return_i : (q.cnt + 14'h1 >= dly_lim);
		if (start_i)
		begin
			// New coordinates abort any strobe in flight so no smear is drawn
			d.state = dac_display_pkg::SEQ_SETTLE;
			d.cnt = 14'h0;
			d.strobe = 1'b0;
		end
		else
		begin
			case (q.state)
				dac_display_pkg::SEQ_IDLE:
				begin
					d.cnt = 14'h0;
				end
				dac_display_pkg::SEQ_SETTLE:
				begin
					d.cnt = q.cnt + 14'h1;
					if (dly_end)
					begin
						d.state = dac_display_pkg::SEQ_STROBE;
						d.cnt = 14'h0;
						d.strobe = 1'b1;
						d.wide = store_i;
					end
				end
				dac_display_pkg::SEQ_STROBE:
				begin
					d.cnt = q.cnt + 14'h1;
					if (q.cnt + 14'h1 >= wid_lim)
					begin
						d.state = dac_display_pkg::SEQ_IDLE;
						d.strobe = 1'b0;
						d.done = 1'b1;
					end
				end
				default:
				begin
					d.state = dac_display_pkg::SEQ_IDLE;
					d.strobe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q <= '0;
		else
			q <= d;
	end

	assign strobe_o = q.strobe;
	assign done_o = q.done;

	logic [13:0] hi_cnt;
	logic [13:0] since_start;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hi_cnt <= 14'h0;
			since_start <= 14'h0;
		end
		else
		begin
			hi_cnt <= q.strobe ? hi_cnt + 14'h1 : 14'h0;
			since_start <= start_i ? 14'h1 : since_start + 14'h1;
		end
	end

	a_strobe_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		q.done |-> hi_cnt == (q.wide ? 14'(`STROBE_LONG_CYC) : 14'(`STROBE_SHORT_CYC)))
		else $error("dot strobe width wrong");
	a_fast_delay: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		($rose(q.strobe) && $past(fast_i)) |-> since_start == 14'(`DLY_FAST_CYC + 1))
		else $error("fast settle delay wrong");
endmodule

/* rtl/bus_irq_request.sv */
// Vectored interrupt request: asks for the bus, then places the vector once granted.
// Assumes an arbiter answering bus_grant_i synchronously to core_clk_i.
`include "dac_display_cfg.svh"
module bus_irq_request #(
	parameter logic [2:0] IRQ_LEVEL  = `IRQ_LEVEL_DEF,
	parameter logic [8:0] IRQ_VECTOR = `IRQ_VECTOR_DEF
)(
	input  wire logic  core_clk_i,
	input  wire logic  rst_n_i,
	input  wire logic  ready_i,
	input  wire logic  ie_i,
	input  wire logic  bus_grant_i,
	output logic       bus_request_line_o,
	output logic       vector_valid_o,
	output logic [8:0] vector_o,
	output logic [2:0] level_o
);
	dac_display_pkg::irq_regs_t q;
	dac_display_pkg::irq_regs_t d;

	always_comb
	begin
		d = q;
		d.vec_valid = 1'b0;
		if (!ready_i)
			d.served = 1'b0;
		if (q.req && bus_grant_i)
		begin
			d.served = 1'b1;
			d.vec_valid = 1'b1;
		end
		// One request per ready event; dropping the enable withdraws it
		d.req = ready_i && ie_i && !d.served;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			q <= '0;
			q.vector <= IRQ_VECTOR;
			q.level <= IRQ_LEVEL;
		end
		else
			q <= d;
	end

	assign bus_request_line_o = q.req;
	assign vector_valid_o = q.vec_valid;
	assign vector_o = q.vector;
	assign level_o = q.level;

	sequence s_granted;
		q.req && bus_grant_i;
	endsequence
	a_req_needs_ie: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		q.req |-> $past(ie_i))
		else $error("bus request without interrupt enable");
	a_ready_raises: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		($rose(ready_i) && ie_i) |=> q.req || q.vec_valid)
		else $error("ready did not raise a request");
	a_grant_vector: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_granted |=> q.vec_valid && !q.req ##1 !q.vec_valid)
		else $error("vector not placed after grant");
	a_vec_after_grant: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		q.vec_valid |-> $past(q.req) && $past(bus_grant_i))
		else $error("vector placed without grant");
endmodule

/* rtl/dac_display_ctrl.sv */
// Four-channel DAC display controller: Wishbone slave, channel buffers, dot timing, interrupts.
// Assumes a classic Wishbone master and display inputs synchronous to core_clk_i.
// Behaviour
// - Four separate 12-bit channel buffers each drive one DAC, beside one display control register.
// - In point plotting channel 0 holds the X and channel 1 the Y coordinate of the dot.
// - Once the coordinates are loaded and settled, the dot strobe is sent without host help.
// - Channels 2 and 3 take no part in dot timing and are plain analog outputs.
// - Control bits select store, erase or superimpose and drive the matching outputs.
// - The bus request never rises while interrupt enable is clear.
// - With interrupt enable set, the ready flag becoming set raises a bus request.
// - Ready and the interrupt mark the end of a dot strobe and the end of an erase.
// - Interrupt level defaults to 4 and vector to 360, both set by parameters.
// - The request asks for the bus first, and the vector goes out only after the grant.
// - Codes are offset binary by default, with two's complement selectable.
// - The X and Y channels span a full 4096 by 4096 grid of dot positions.
// - A pen-down output serves X/Y recorders, with new coordinates moving the pen.
// - Each of the four channels drives one strip chart pen continuously from its code.
// - The dot strobe lasts 2 us, or 6 us in store mode.
// - Settling takes 3 us in fast mode, else 20 us or 80 us, or ends on the delay return.
`include "dac_display_cfg.svh"
module dac_display_ctrl #(
	parameter int         LONG_DELAY_CYCLES = `DLY_LONG_CYC,
	parameter logic [2:0] IRQ_LEVEL         = `IRQ_LEVEL_DEF,
	parameter logic [8:0] IRQ_VECTOR        = `IRQ_VECTOR_DEF
)(
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	output logic [11:0]      dac0_code_o,
	output logic [11:0]      dac1_code_o,
	output logic [11:0]      dac2_code_o,
	output logic [11:0]      dac3_code_o,
	output logic             dot_strobe_o,
	output logic             store_o,
	output logic             erase_o,
	output logic             superimpose_output_o,
	output logic             pen_down_o,
	output logic             ready_o,
	input  wire logic        erase_return_i,
	input  wire logic        delay_return_i,
	output logic             irq_o,
	output logic             bus_request_line_o,
	input  wire logic        bus_grant_i,
	output logic             vector_valid_o,
	output logic [8:0]       vector_o,
	output logic [2:0]       irq_level_o
);
	dac_display_pkg::top_regs_t q;
	dac_display_pkg::top_regs_t d;

	logic        acc;
	logic        wr;
	logic        chan_hit;
	logic [1:0]  idx;
	logic [31:0] merged;
	logic        cwr;
	logic        erase_start;
	logic        erase_end;
	logic        dsr_wr;
	logic [1:0]  evt_set;
	logic [1:0]  evt_clr;
	logic        seq_done;
	logic        seq_strobe;

	// Byte lanes that are not selected keep the old contents
	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				r[8*b +: 8] = new_v[8*b +: 8];
		end
		return r;
	endfunction

	always_comb
	begin
		d = q;
		acc = wb_cyc_i && wb_stb_i && !q.ack;
		wr = acc && wb_we_i;
		chan_hit = (wb_adr_i & `ADR_PAGE_MASK) == `OFS_CHAN_BASE;
		idx = wb_adr_i[3:2];
		merged = 32'h0;
		cwr = 1'b0;
		erase_start = 1'b0;
		dsr_wr = 1'b0;
		evt_clr = 2'h0;
		evt_set = 2'h0;
		d.ack = acc;
		d.rdata = 32'h0;
		d.start = 1'b0;

		if (acc && !wb_we_i)
		begin
			if (chan_hit)
				d.rdata = {20'h0, q.chan[idx]};
			else if (wb_adr_i == `OFS_DSR)
				d.rdata = {22'h0, q.dsr};
			else if (wb_adr_i == `OFS_EVT)
				d.rdata = {30'h0, q.evt};
			else if (wb_adr_i == `OFS_MASK)
				d.rdata = {30'h0, q.mask};
		end

		// Hardware completions
		erase_end = q.dsr[`DSR_ERASE] && erase_return_i;
		if (seq_done)
		begin
			evt_set[`EVT_DOT] = 1'b1;
			// A done just after a new write belongs to the old dot
			if (!q.start)
				d.dsr[`DSR_READY] = 1'b1;
		end
		if (erase_end)
		begin
			evt_set[`EVT_ERASE] = 1'b1;
			d.dsr[`DSR_ERASE] = 1'b0;
			d.dsr[`DSR_READY] = 1'b1;
		end

		if (wr)
		begin
			if (chan_hit)
			begin
				merged = merge({20'h0, q.chan[idx]}, wb_dat_i, wb_sel_i);
				d.chan[idx] = merged[11:0];
				// Only X and Y start the dot timing
				cwr = !idx[1];
			end
			else if (wb_adr_i == `OFS_DSR)
			begin
				dsr_wr = 1'b1;
				merged = merge({22'h0, q.dsr}, wb_dat_i, wb_sel_i);
				d.dsr = (merged[9:0] & `DSR_WMASK) | (d.dsr & ~`DSR_WMASK);
				erase_start = merged[`DSR_ERASE] && !q.dsr[`DSR_ERASE];
			end
			else if (wb_adr_i == `OFS_EVT)
			begin
				if (wb_sel_i[0])
					evt_clr = wb_dat_i[1:0];
			end
			else if (wb_adr_i == `OFS_MASK)
			begin
				if (wb_sel_i[0])
					d.mask = wb_dat_i[1:0];
			end
		end

		// A new operation outranks a completion of the previous one
		if (cwr || erase_start)
			d.dsr[`DSR_READY] = 1'b0;
		d.start = cwr;
		// Set wins over write-one-to-clear
		d.evt = (q.evt & ~evt_clr) | evt_set;
		d.irq = |(d.evt & d.mask);

		for (int i = 0; i < 4; i++)
		begin
			d.dac[i] = d.dsr[`DSR_TWOS] ? (d.chan[i] ^ `CODE_MSB) : d.chan[i];
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			q <= '0;
			q.dsr <= `DSR_RESET;
		end
		else
			q <= d;
	end

	dot_sequencer #(
		.LONG_DELAY_CYCLES (LONG_DELAY_CYCLES)
	) u_dot (
		.core_clk_i     (core_clk_i),
		.rst_n_i        (rst_n_i),
		.start_i        (q.start),
		.fast_i         (q.dsr[`DSR_FAST]),
		.long_i         (q.dsr[`DSR_DLY_LONG]),
		.ext_i          (q.dsr[`DSR_DLY_EXT]),
		.store_i        (q.dsr[`DSR_STORE]),
		.delay_return_i (delay_return_i),
		.strobe_o       (seq_strobe),
		.done_o         (seq_done)
	);

	bus_irq_request #(
		.IRQ_LEVEL  (IRQ_LEVEL),
		.IRQ_VECTOR (IRQ_VECTOR)
	) u_irq (
		.core_clk_i         (core_clk_i),
		.rst_n_i            (rst_n_i),
		.ready_i            (q.dsr[`DSR_READY]),
		.ie_i               (q.dsr[`DSR_IE]),
		.bus_grant_i        (bus_grant_i),
		.bus_request_line_o (bus_request_line_o),
		.vector_valid_o     (vector_valid_o),
		.vector_o           (vector_o),
		.level_o            (irq_level_o)
	);

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdata;
	assign dac0_code_o = q.dac[0];
	assign dac1_code_o = q.dac[1];
	assign dac2_code_o = q.dac[2];
	assign dac3_code_o = q.dac[3];
	assign dot_strobe_o = seq_strobe;
	assign store_o = q.dsr[`DSR_STORE];
	assign erase_o = q.dsr[`DSR_ERASE];
	assign superimpose_output_o = q.dsr[`DSR_SUPER];
	assign pen_down_o = q.dsr[`DSR_PEN];
	assign ready_o = q.dsr[`DSR_READY];
	assign irq_o = q.irq;

	sequence s_erase_end;
		erase_o && erase_return_i && !dsr_wr && !cwr;
	endsequence

	a_coord_clears_ready: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cwr && !erase_o) |=> !ready_o ##1 !ready_o)
		else $error("coordinate write left ready set");
	a_dot_sets_ready: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(seq_done && !cwr && !erase_start && !q.start) |=> ready_o && q.evt[`EVT_DOT])
		else $error("dot completion not flagged");
	a_erase_done: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s_erase_end |=> !erase_o && ready_o && q.evt[`EVT_ERASE])
		else $error("erase completion not flagged");
	a_coord_starts_dot: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cwr && !q.dsr[`DSR_FAST] && !q.dsr[`DSR_DLY_EXT]) |=> ##1 !dot_strobe_o[*8])
		else $error("dot strobe before settling");
	a_twos_code: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr && chan_hit && idx == 2'h2 && wb_sel_i == 4'hF && !dsr_wr)
		|=> dac2_code_o == ($past(wb_dat_i[11:0]) ^ (q.dsr[`DSR_TWOS] ? `CODE_MSB : 12'h000)))
		else $error("channel code mapping wrong");
	a_mode_outputs: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(dsr_wr && wb_sel_i[0] && !erase_end)
		|=> store_o == $past(wb_dat_i[`DSR_STORE])
		&& superimpose_output_o == $past(wb_dat_i[`DSR_SUPER]))
		else $error("mode outputs do not follow control bits");
	a_irq_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		irq_o == |(q.evt & q.mask))
		else $error("interrupt output disagrees with status and mask");
endmodule

/* test/host_model.sv */
// Host processor model: Wishbone classic master tasks and the system bus arbiter.
// Assumes a slave that acks with a registered pulse; grant delay is set by the bench.
module host_model (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	input  wire logic        bus_req_i,
	input  wire logic        vec_valid_i,
	input  wire logic [8:0]  vec_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [7:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o,
	output logic             grant_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int         grant_wait = 0;
	int         gcnt       = 0;
	int         vec_count  = 0;
	int         timeouts   = 0;
	logic [8:0] vec_seen   = 9'h000;

	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
		grant_o = 1'b0;
	end

	// One classic cycle; request held until ack is sampled high
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 50);
		if (n >= 50)
			timeouts++;
		r = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Released data lines must not keep looking valid
		dat_o <= ~d;
	endtask

	// Grant only to a standing request, promptly or after grant_wait cycles
	always @(posedge clk_i)
	begin
		grant_o <= 1'b0;
		if (vec_valid_i === 1'b1)
		begin
			vec_count <= vec_count + 1;
			vec_seen <= vec_i;
		end
		if (bus_req_i !== 1'b1 || grant_o)
			gcnt <= 0;
		else if (gcnt >= grant_wait)
			grant_o <= 1'b1;
		else
			gcnt <= gcnt + 1;
	end
endmodule

/* test/tb_top.sv */
// Self-checking bench of the display controller, host model on the register bus.
// Assumes the 100 MHz core clock and a shortened long settle delay.
`include "dac_display_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LONG_CYC = 50;
	logic             clk = 1'b0;
	logic             rst_n = 1'b0;
	logic             cyc, stb, we, ack, strobe, store, erase, sup, pen, ready, irq;
	logic             breq, grant, vvalid;
	logic             erase_ret = 1'b0;
	logic             delay_ret = 1'b0;
	logic [7:0]       adr;
	logic [3:0]       sel;
	logic [31:0]      wdat, rdat;
	logic [11:0]      dac0, dac1, dac2, dac3;
	logic [8:0]       vec;
	logic [2:0]       lvl;
	logic             mask_on = 1'b0;
	int               failures = 0;
	int               compares = 0;

	initial
	begin
		forever #5 clk = ~clk;
	end

	dac_display_ctrl #(.LONG_DELAY_CYCLES(LONG_CYC)) i_dac_display_ctrl (
		.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.dac0_code_o(dac0), .dac1_code_o(dac1), .dac2_code_o(dac2), .dac3_code_o(dac3),
		.dot_strobe_o(strobe), .store_o(store), .erase_o(erase), .superimpose_output_o(sup),
		.pen_down_o(pen), .ready_o(ready), .erase_return_i(erase_ret),
		.delay_return_i(delay_ret), .irq_o(irq), .bus_request_line_o(breq),
		.bus_grant_i(grant), .vector_valid_o(vvalid), .vector_o(vec), .irq_level_o(lvl));

	host_model i_host (
		.clk_i(clk), .ack_i(ack), .dat_i(rdat), .bus_req_i(breq), .vec_valid_i(vvalid),
		.vec_i(vec), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat), .grant_o(grant));

	task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		i_host.access(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		i_host.access(1'b0, a, 32'h0000_0000, r);
	endtask

	// Sample one nanosecond after the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 3000)
		begin
			tick(1);
			n++;
		end
		chk("ready wait", ready, 1'b1);
	endtask

	task automatic reg_run;
		logic [31:0] r;
		rd(`OFS_DSR, r);
		chk("dsr reset", r, 48'h080);
		rd(8'h40, r);
		chk("unmapped read", r, 48'h0);
		wr(`OFS_CHAN_BASE + 8'h08, 32'h0000_0000);
		wr(`OFS_CHAN_BASE + 8'h0C, 32'h0000_0FFF);
		tick(2);
		chk("ready after ch2 ch3", ready, 1'b1);
		wr(`OFS_CHAN_BASE, 32'h0000_0800);
		wr(`OFS_CHAN_BASE + 8'h04, 32'h0000_07FF);
		tick(1);
		chk("dac codes", {dac3, dac2, dac1, dac0}, 48'hFFF0007FF800);
		rd(`OFS_CHAN_BASE, r);
		chk("ch0 readback", r, 48'h800);
		wait_ready;
		wr(`OFS_DSR, 32'h0000_0040);
		tick(1);
		chk("twos codes", {dac3, dac2, dac1, dac0}, 48'h7FF800FFF000);
		wr(`OFS_DSR, 32'h0000_0025);
		tick(1);
		chk("store sup pen erase", {store, sup, pen, erase}, 48'hE);
		rd(`OFS_DSR, r);
		chk("dsr readback", r, 48'h0A5);
	endtask

	task automatic erase_run;
		logic [31:0] r;
		wr(`OFS_DSR, 32'h0000_0002);
		tick(1);
		chk("erase out", erase, 1'b1);
		chk("ready in erase", ready, 1'b0);
		tick(5);
		chk("erase held", erase, 1'b1);
		@(posedge clk);
		erase_ret <= 1'b1;
		@(posedge clk);
		erase_ret <= 1'b0;
		tick(2);
		chk("erase end", {erase, ready}, 48'h1);
		rd(`OFS_EVT, r);
		chk("erase event", r[1], 1'b1);
	endtask

	// Writes X then Y; settle < 0 means ended by the delay return
	task automatic dot_run(input logic [31:0] mode, input int settle, input int width);
		int n;
		wr(`OFS_DSR, mode);
		wr(`OFS_CHAN_BASE, 32'h0000_0ABC);
		wr(`OFS_CHAN_BASE + 8'h04, 32'h0000_0FFF);
		tick(1);
		n = 1;
		chk("ready after write", ready, 1'b0);
		chk("xy codes", {dac1, dac0}, 48'hFFFABC);
		while (strobe !== 1'b1 && n < 2400)
		begin
			@(posedge clk);
			delay_ret <= (settle < 0 && n == 2050);
			#1;
			n++;
		end
		if (settle < 0)
			chk("ext settle", n > 2051 && n < 2058, 1'b1);
		else
			chk("settle cycles", n, settle);
		n = 0;
		while (strobe === 1'b1 && n < 700)
		begin
			tick(1);
			n++;
		end
		chk("strobe width", n, width);
		tick(1);
		chk("ready after dot", ready, 1'b1);
		chk("irq level", irq, mask_on);
		wr(`OFS_EVT, 32'h0000_0001);
		tick(1);
		chk("irq cleared", irq, 1'b0);
	endtask

	task automatic wait_vec(input int k);
		int n;
		n = 0;
		while (i_host.vec_count < k && n < 200)
		begin
			tick(1);
			n++;
		end
		chk("vector count", i_host.vec_count, k);
	endtask

	task automatic irq_run;
		wr(`OFS_MASK, 32'h0000_0001);
		mask_on = 1'b1;
		dot_run(32'h0000_0008, 300, 200);
		chk("request without enable", breq, 1'b0);
		i_host.grant_wait = 20;
		wr(`OFS_DSR, 32'h0000_0018);
		tick(3);
		chk("request raised", breq, 1'b1);
		chk("vector before grant", i_host.vec_count, 0);
		wait_vec(1);
		chk("vector", i_host.vec_seen, 48'h0F0);
		chk("level", lvl, 48'h4);
		chk("request after grant", breq, 1'b0);
		i_host.grant_wait = 0;
		dot_run(32'h0000_0018, 300, 200);
		wait_vec(2);
	endtask

	task automatic summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (40000) @(posedge clk);
		failures++;
		summarize;
	end

	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		chk("reset outputs", {ready, breq, irq, strobe}, 48'h8);
		reg_run;
		erase_run;
		dot_run(32'h0000_0008, 300, 200);
		dot_run(32'h0000_0000, 2000, 200);
		dot_run(32'h0000_0101, LONG_CYC, 600);
		dot_run(32'h0000_0200, -1, 200);
		irq_run;
		chk("bus timeouts", i_host.timeouts, 0);
		summarize;
	end
endmodule
